// file: design/oscmc_ctrl.sv
// Purpose: Oscillator mode, start-up counter and internal oscillator control
// Assumes: Pins and oscillator taps arrive asynchronous to pclk
// Notes: Analog oscillators and amplifier sit outside this logic
//
// Overview of operation
// - Crystal modes count 1024 clock input edges before start-up ends.
// - Start-up count begins after power-on (post power-up timer) and wake.
// - Execution held suspended while the start-up count runs.
// - Driven clock mode skips the crystal count entirely.
// - Driven mode: clock enters pin A, pin B released as GPIO.
// - Fully static; stopped clock freezes state, resumes where it stopped.
// - Crystal mode picks low, medium or high amplifier gain.
// - RC mode drives pin B with RC clock divided by four.
// - RC GPIO mode: network on pin A, pin B is GPIO.
// - Internal-with-output: pin A GPIO, pin B internal clock over four.
// - Internal all-GPIO: both pins GPIO, no clock out.
// - Fast oscillator nominal 8 MHz, seven divided choices.
// - Fast oscillator on when choice nonzero and internal or two-speed.
// - Readable flag shows fast oscillator stability.
// - Trim is 5-bit two's complement, resets to zero.
// - Trim write shifts fast oscillator, no completion flag.
// - Trim never reaches the slow oscillator or its users.
// - Slow oscillator is uncalibrated, nominal 31 kHz.
// - Warm-up delay before internal oscillator use after sleep or power-on.
// - Software bit chooses configured source or internal oscillators.
// - Choice bit 1 selects internal, 0 selects configured mode.
// - Choice 111 is 8 MHz halving to 001, 000 is 31 kHz, reset 110.
`timescale 1ns/1ps
module oscmc_ctrl #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Configuration and system events
    input wire logic [2:0] config_clock_mode,
    input wire logic two_speed_start_enable,
    input wire logic power_up_timer_enable,
    input wire logic power_up_timer_done,
    input wire logic watchdog_enable,
    input wire logic clock_fail_monitor_enable,
    input wire logic sleep_wake,
    // Pins and oscillator taps
    input wire logic clock_in_pin_a,
    input wire logic int_osc_tap,
    output logic clock_out_pin_b_o,
    output logic clock_out_pin_b_oe,
    output logic pin_a_gpio_release,
    output logic pin_b_gpio_release,
    // Analog and core controls
    output logic [1:0] amp_gain,
    output logic fast_osc_enable,
    output logic slow_osc_enable,
    output logic [4:0] fast_osc_trim,
    output logic internal_clock_sel,
    output logic cpu_hold
);
    if (ADDR_W < 4 || ADDR_W > 32) begin : g_addr_w_bad
        $error("ADDR_W out of range");
    end

    typedef enum logic [2:0] {
        ST_PUP_WAIT, ST_COUNT, ST_WARM, ST_RUN, ST_START
    } oscmc_state_e;

    localparam logic [10:0] XTAL_LAST = 11'(oscmc_pkg::XTAL_COUNT);
    localparam logic [8:0] WARM_LAST = 9'(oscmc_pkg::WARM_CYC);

    function automatic logic [15:0] nominal_khz(input logic [2:0] sel);
        nominal_khz = (sel == oscmc_pkg::FREQ_SLOW) ?
            oscmc_pkg::SLOW_OSC_KHZ :
            16'(oscmc_pkg::FAST_OSC_KHZ >> (3'h7 - sel));
    endfunction

    function automatic logic is_crystal(input logic [2:0] m);
        is_crystal = (m == oscmc_pkg::MODE_WATCH) ||
            (m == oscmc_pkg::MODE_MEDIUM) || (m == oscmc_pkg::MODE_HIGH);
    endfunction

    function automatic logic is_internal(input logic [2:0] m);
        is_internal = (m == oscmc_pkg::MODE_INTOUT) ||
            (m == oscmc_pkg::MODE_INTIO);
    endfunction

    // Synchronisers, edge detect on second stage only
    logic [2:0] pin_a_sync_ff;
    logic [2:0] tap_sync_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_a_sync_ff <= 3'h0;
            tap_sync_ff <= 3'h0;
        end else begin
            pin_a_sync_ff <= {pin_a_sync_ff[1:0], clock_in_pin_a};
            tap_sync_ff <= {tap_sync_ff[1:0], int_osc_tap};
        end
    end
    logic pin_a_rise;
    logic tap_rise;
    assign pin_a_rise = pin_a_sync_ff[1] & ~pin_a_sync_ff[2];
    assign tap_rise = tap_sync_ff[1] & ~tap_sync_ff[2];

    // Register file
    logic [2:0] freq_sel_ff;
    logic sys_sel_ff;
    logic [4:0] trim_ff;
    logic fast_stable_ff;
    logic slow_stable_ff;
    oscmc_state_e state_ff;
    logic setup_rd;
    logic wr_en;
    logic addr_ok;
    assign setup_rd = psel & ~penable & ~pwrite;
    assign wr_en = psel & penable & pwrite;
    assign addr_ok = (paddr == ADDR_W'(oscmc_pkg::CTRL_OFS)) ||
        (paddr == ADDR_W'(oscmc_pkg::TRIM_OFS)) ||
        (paddr == ADDR_W'(oscmc_pkg::FREQ_OFS));
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            freq_sel_ff <= oscmc_pkg::FREQ_RST;
            sys_sel_ff <= oscmc_pkg::SYS_SEL_RST;
        end else if (wr_en && paddr == ADDR_W'(oscmc_pkg::CTRL_OFS)) begin
            freq_sel_ff <= pwdata[oscmc_pkg::FREQ_LSB +: 3];
            sys_sel_ff <= pwdata[oscmc_pkg::SYS_SEL_BIT];
        end
    end

    // Trim only drives the fast oscillator; no done flag exists
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trim_ff <= oscmc_pkg::TRIM_RST;
        end else if (wr_en && paddr == ADDR_W'(oscmc_pkg::TRIM_OFS)) begin
            trim_ff <= pwdata[oscmc_pkg::TRIM_W-1:0];
        end
    end
    assign fast_osc_trim = trim_ff;

    logic [31:0] nxt_rdata;
    always_comb begin
        nxt_rdata = 32'h0;
        if (paddr == ADDR_W'(oscmc_pkg::CTRL_OFS)) begin
            nxt_rdata[oscmc_pkg::FREQ_LSB +: 3] = freq_sel_ff;
            nxt_rdata[oscmc_pkg::EXT_ACT_BIT] =
                (state_ff == ST_RUN) & ~internal_clock_sel;
            nxt_rdata[oscmc_pkg::FAST_STB_BIT] = fast_stable_ff;
            nxt_rdata[oscmc_pkg::SLOW_STB_BIT] = slow_stable_ff;
            nxt_rdata[oscmc_pkg::SYS_SEL_BIT] = sys_sel_ff;
        end else if (paddr == ADDR_W'(oscmc_pkg::TRIM_OFS)) begin
            nxt_rdata[oscmc_pkg::TRIM_W-1:0] = trim_ff;
        end else if (paddr == ADDR_W'(oscmc_pkg::FREQ_OFS)) begin
            nxt_rdata[15:0] = nominal_khz(freq_sel_ff);
        end
    end

    logic [31:0] rdata_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_ff <= 32'h0;
        end else if (setup_rd) begin
            rdata_ff <= nxt_rdata;
        end
    end
    assign prdata = rdata_ff;

    // Source choice and oscillator enables
    assign internal_clock_sel =
        sys_sel_ff | is_internal(config_clock_mode);
    assign fast_osc_enable = (freq_sel_ff != oscmc_pkg::FREQ_SLOW) &
        (internal_clock_sel | two_speed_start_enable);
    assign slow_osc_enable = ((freq_sel_ff == oscmc_pkg::FREQ_SLOW) &
        (internal_clock_sel | two_speed_start_enable)) |
        power_up_timer_enable | watchdog_enable |
        clock_fail_monitor_enable;

    // Stability: warm-up after each enable
    logic [8:0] fast_warm_ff;
    logic [8:0] slow_warm_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_warm_ff <= 9'h0;
            fast_stable_ff <= 1'b0;
        end else if (!fast_osc_enable) begin
            fast_warm_ff <= 9'h0;
            fast_stable_ff <= 1'b0;
        end else if (fast_warm_ff != WARM_LAST) begin
            fast_warm_ff <= fast_warm_ff + 9'h1;
        end else begin
            fast_stable_ff <= 1'b1;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_warm_ff <= 9'h0;
            slow_stable_ff <= 1'b0;
        end else if (!slow_osc_enable) begin
            slow_warm_ff <= 9'h0;
            slow_stable_ff <= 1'b0;
        end else if (slow_warm_ff != WARM_LAST) begin
            slow_warm_ff <= slow_warm_ff + 9'h1;
        end else begin
            slow_stable_ff <= 1'b1;
        end
    end

    // Start-up sequencer; reset release counts as the power-on event
    logic [10:0] xtal_cnt_ff;
    logic [8:0] warm_cnt_ff;
    logic por_pend_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= ST_START;
            por_pend_ff <= 1'b1;
        end else begin
            case (state_ff)
                ST_START: begin
                    if (por_pend_ff && power_up_timer_enable) begin
                        state_ff <= ST_PUP_WAIT;
                    end else if (internal_clock_sel) begin
                        state_ff <= ST_WARM;
                    end else if (is_crystal(config_clock_mode)) begin
                        state_ff <= ST_COUNT;
                    end else begin
                        state_ff <= ST_RUN;
                    end
                    por_pend_ff <= 1'b0;
                end
                ST_PUP_WAIT: begin
                    if (power_up_timer_done) begin
                        state_ff <= internal_clock_sel ? ST_WARM :
                            is_crystal(config_clock_mode) ? ST_COUNT :
                            ST_RUN;
                    end
                end
                ST_COUNT: begin
                    if (xtal_cnt_ff == XTAL_LAST) begin
                        state_ff <= ST_RUN;
                    end
                end
                ST_WARM: begin
                    if (warm_cnt_ff == WARM_LAST) begin
                        state_ff <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (sleep_wake) begin
                        state_ff <= ST_START;
                    end
                end
                default: begin
                    state_ff <= ST_START;
                end
            endcase
        end
    end

    // Counts only pin edges, so a stopped clock just freezes it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xtal_cnt_ff <= 11'h0;
        end else if (state_ff != ST_COUNT) begin
            xtal_cnt_ff <= 11'h0;
        end else if (pin_a_rise && xtal_cnt_ff != XTAL_LAST) begin
            xtal_cnt_ff <= xtal_cnt_ff + 11'h1;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            warm_cnt_ff <= 9'h0;
        end else if (state_ff != ST_WARM) begin
            warm_cnt_ff <= 9'h0;
        end else if (warm_cnt_ff != WARM_LAST) begin
            warm_cnt_ff <= warm_cnt_ff + 9'h1;
        end
    end
    assign cpu_hold = (state_ff != ST_RUN);

    // Amplifier gain per crystal mode
    always_comb begin
        case (config_clock_mode)
            oscmc_pkg::MODE_WATCH: amp_gain = oscmc_pkg::GAIN_LOW;
            oscmc_pkg::MODE_MEDIUM: amp_gain = oscmc_pkg::GAIN_MID;
            oscmc_pkg::MODE_HIGH: amp_gain = oscmc_pkg::GAIN_HIGH;
            default: amp_gain = oscmc_pkg::GAIN_OFF;
        endcase
    end

    // Pin ownership per mode
    logic divout_mode;
    assign divout_mode = (config_clock_mode == oscmc_pkg::MODE_RC) ||
        (config_clock_mode == oscmc_pkg::MODE_INTOUT);
    assign pin_a_gpio_release = is_internal(config_clock_mode);
    assign pin_b_gpio_release =
        (config_clock_mode == oscmc_pkg::MODE_DRIVEN) ||
        (config_clock_mode == oscmc_pkg::MODE_RCGPIO) ||
        (config_clock_mode == oscmc_pkg::MODE_INTIO);

    // Divide by four: toggle every second source edge
    logic div_src;
    logic div_half_ff;
    logic div_out_ff;
    assign div_src = (config_clock_mode == oscmc_pkg::MODE_RC) ?
        pin_a_rise : tap_rise;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_half_ff <= 1'b0;
            div_out_ff <= 1'b0;
        end else if (!divout_mode) begin
            div_half_ff <= 1'b0;
            div_out_ff <= 1'b0;
        end else if (div_src) begin
            div_half_ff <= ~div_half_ff;
            if (div_half_ff) begin
                div_out_ff <= ~div_out_ff;
            end
        end
    end
    assign clock_out_pin_b_o = div_out_ff;
    assign clock_out_pin_b_oe = divout_mode;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_xtal_release;
        (state_ff == ST_COUNT && xtal_cnt_ff != XTAL_LAST) |=>
            state_ff != ST_RUN;
    endproperty
    a_xtal_release: assert property (p_xtal_release)
        else $error("crystal count released early");

    // Execution may only resume from a finished count or another state
    property p_hold;
        $fell(cpu_hold) |-> $past(state_ff) != ST_COUNT ||
            $past(xtal_cnt_ff) == XTAL_LAST;
    endproperty
    a_hold: assert property (p_hold)
        else $error("execution not held during start-up");

    property p_driven_nodelay;
        (state_ff == ST_START && !internal_clock_sel &&
         config_clock_mode == oscmc_pkg::MODE_DRIVEN &&
         !(por_pend_ff && power_up_timer_enable)) |=> !cpu_hold;
    endproperty
    a_driven_nodelay: assert property (p_driven_nodelay)
        else $error("driven mode delayed");

    property p_wake_restart;
        (state_ff == ST_RUN && sleep_wake) |=> cpu_hold;
    endproperty
    a_wake_restart: assert property (p_wake_restart)
        else $error("wake did not restart start-up");

    property p_fast_en;
        fast_osc_enable == ((freq_sel_ff != 3'h0) &&
            (sys_sel_ff || is_internal(config_clock_mode) ||
             two_speed_start_enable));
    endproperty
    a_fast_en: assert property (p_fast_en)
        else $error("fast oscillator enable wrong");

    property p_stable_warm;
        $rose(fast_stable_ff) |-> $past(fast_osc_enable, 2);
    endproperty
    a_stable_warm: assert property (p_stable_warm)
        else $error("stable flag without warm-up");

    property p_gain;
        (config_clock_mode == oscmc_pkg::MODE_HIGH) |->
            amp_gain == oscmc_pkg::GAIN_HIGH;
    endproperty
    a_gain: assert property (p_gain)
        else $error("high gain not chosen");

    property p_no_divout;
        (config_clock_mode == oscmc_pkg::MODE_INTIO) |->
            !clock_out_pin_b_oe && pin_a_gpio_release && pin_b_gpio_release;
    endproperty
    a_no_divout: assert property (p_no_divout)
        else $error("clock driven in all-GPIO mode");

    property p_div4;
        (divout_mode && div_src && div_half_ff && $stable(divout_mode)) |=>
            clock_out_pin_b_o != $past(clock_out_pin_b_o);
    endproperty
    a_div4: assert property (p_div4)
        else $error("divided clock missed toggle");
endmodule

// file: design/oscmc_pkg.sv
// Purpose: Shared constants for the oscillator mode and start-up control
// Assumes: 100 MHz pclk, APB register access
// Notes: Offsets are byte addresses of 32-bit words
package oscmc_pkg;
    // Clock rate
    localparam int unsigned CLK_HZ = 100_000_000;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] TRIM_OFS = 8'h04;
    localparam logic [7:0] FREQ_OFS = 8'h08;
    // Control register fields
    localparam int FREQ_LSB = 4;
    localparam int EXT_ACT_BIT = 3;
    localparam int FAST_STB_BIT = 2;
    localparam int SLOW_STB_BIT = 1;
    localparam int SYS_SEL_BIT = 0;
    localparam logic [2:0] FREQ_RST = 3'h6;
    localparam logic [2:0] FREQ_SLOW = 3'h0;
    localparam logic SYS_SEL_RST = 1'b0;
    localparam int TRIM_W = 5;
    localparam logic [4:0] TRIM_RST = 5'h00;
    // Configured clock modes
    localparam logic [2:0] MODE_WATCH = 3'h0;
    localparam logic [2:0] MODE_MEDIUM = 3'h1;
    localparam logic [2:0] MODE_HIGH = 3'h2;
    localparam logic [2:0] MODE_RC = 3'h3;
    localparam logic [2:0] MODE_RCGPIO = 3'h4;
    localparam logic [2:0] MODE_INTOUT = 3'h5;
    localparam logic [2:0] MODE_INTIO = 3'h6;
    localparam logic [2:0] MODE_DRIVEN = 3'h7;
    // Amplifier gain codes
    localparam logic [1:0] GAIN_OFF = 2'h0;
    localparam logic [1:0] GAIN_LOW = 2'h1;
    localparam logic [1:0] GAIN_MID = 2'h2;
    localparam logic [1:0] GAIN_HIGH = 2'h3;
    // Start-up timing
    localparam int unsigned XTAL_COUNT = 1024;
    localparam int unsigned T_WARM_NS = 2000;
    localparam int unsigned WARM_CYC =
        (T_WARM_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned CLK_DIV = 4;
    // Nominal oscillator rates in kHz
    localparam logic [15:0] FAST_OSC_KHZ = 16'h1f40;
    localparam logic [15:0] SLOW_OSC_KHZ = 16'h001f;
endpackage

// file: test/oscmc_xtal_model.sv
// Purpose: Crystal or driven clock source beyond the oscillator pins
// Assumes: Free-running, unrelated in phase to pclk
// Notes: Tap runs at half the pin rate so the two sources differ
`timescale 1ns/1ps
module oscmc_xtal_model #(
    parameter int HALF_NS = 35
) (
    // Bench control
    input wire logic run,
    input wire logic slow,
    input wire logic clr,
    // Pin side
    output logic pin_clk,
    output logic tap_clk,
    output int edges
);
    // Logic-level clock on pin A; parks low when stopped
    initial begin
        pin_clk = 1'b0;
        tap_clk = 1'b0;
        forever begin
            #(slow ? 3 * HALF_NS : HALF_NS);
            if (run) begin
                pin_clk = ~pin_clk;
                if (pin_clk) begin
                    tap_clk = ~tap_clk;
                end
            end else begin
                pin_clk = 1'b0;
            end
        end
    end
    always @(posedge pin_clk or posedge clr) begin
        if (clr) begin
            edges <= 0;
        end else begin
            edges <= edges + 1;
        end
    end
endmodule

// file: test/oscmc_ctrl_tb.sv
// Purpose: Self-checking bench for oscillator mode and start-up control
// Assumes: Partner model drives pin A and the internal tap
// Notes: Mode changes go through a reset, as on a real part, except the t_pins mode sweep
`timescale 1ns/1ps
module oscmc_ctrl_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd, sv;
    logic pready, pslverr, err, b_o, b_oe, rel_a, rel_b, pin_a, tap;
    logic [2:0] mode = oscmc_pkg::MODE_DRIVEN;
    logic two_spd = 1'b0;
    logic put_en = 1'b0;
    logic put_done = 1'b0;
    logic wdog_en = 1'b0;
    logic fail_en = 1'b0;
    logic wake = 1'b0;
    logic run = 1'b0;
    logic slow = 1'b0;
    logic clr = 1'b0;
    logic [1:0] gain;
    logic fast_en, slow_en, int_sel, cpu_hold;
    logic [4:0] trim;
    int edges, n;
    int miscompares = 0;
    int cmp_count = 0;
    int b_rises = 0;
    // Expected {oe, release a, release b, gain} per mode
    logic [4:0] pins [8] = '{5'h01, 5'h02, 5'h03, 5'h10,
                                5'h04, 5'h18, 5'h0c, 5'h04};

    always #5 pclk = ~pclk;
    always @(posedge b_o) b_rises++;

    oscmc_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .config_clock_mode(mode),
        .two_speed_start_enable(two_spd), .power_up_timer_enable(put_en),
        .power_up_timer_done(put_done), .watchdog_enable(wdog_en),
        .clock_fail_monitor_enable(fail_en), .sleep_wake(wake),
        .clock_in_pin_a(pin_a), .int_osc_tap(tap),
        .clock_out_pin_b_o(b_o), .clock_out_pin_b_oe(b_oe),
        .pin_a_gpio_release(rel_a), .pin_b_gpio_release(rel_b),
        .amp_gain(gain), .fast_osc_enable(fast_en),
        .slow_osc_enable(slow_en), .fast_osc_trim(trim),
        .internal_clock_sel(int_sel), .cpu_hold(cpu_hold));

    oscmc_xtal_model model (.run(run), .slow(slow), .clr(clr),
        .pin_clk(pin_a), .tap_clk(tap), .edges(edges));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a slave that never answers
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rst(input logic [2:0] m, input logic pe);
        @(posedge pclk);
        presetn <= 1'b0;
        mode <= m;
        put_en <= pe;
        put_done <= 1'b0;
        run <= 1'b0;
        clr <= 1'b1;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        clr <= 1'b0;
    endtask

    // Sampled on the falling edge so updates have landed
    task automatic wait_run(input int lim);
        n = 0;
        while (cpu_hold !== 1'b0 && n < lim) begin
            @(negedge pclk);
            n++;
        end
        chk(cpu_hold, 1'b0);
    endtask

    task automatic t_regs();
        rst(oscmc_pkg::MODE_DRIVEN, 1'b0);
        wait_run(50);
        apb(1'b0, oscmc_pkg::CTRL_OFS, 32'h0);
        chk(rd & 32'h7f, 32'h68);
        apb(1'b0, oscmc_pkg::TRIM_OFS, 32'h0);
        chk(rd, 32'h0);
        for (int s = 0; s < 8; s++) begin
            apb(1'b1, oscmc_pkg::CTRL_OFS, 32'(s << 4) | 32'h1);
            apb(1'b0, oscmc_pkg::FREQ_OFS, 32'h0);
            chk(rd, s == 0 ? 32'h1f : 32'h1f40 >> (7 - s));
            chk(fast_en, s != 0);
            chk(int_sel, 1'b1);
        end
        apb(1'b1, oscmc_pkg::CTRL_OFS, 32'h60);
        apb(1'b0, oscmc_pkg::CTRL_OFS, 32'h0);
        chk({int_sel, fast_en}, 2'h0);
        two_spd <= 1'b1;
        apb(1'b0, oscmc_pkg::CTRL_OFS, 32'h0);
        chk(fast_en, 1'b1);
        two_spd <= 1'b0;
        apb(1'b1, oscmc_pkg::CTRL_OFS, 32'h71);
        repeat (210) @(posedge pclk);
        apb(1'b0, oscmc_pkg::CTRL_OFS, 32'h0);
        chk(rd[2], 1'b1);
        sv = rd;
        // Lowest trim value; upper bits must be dropped
        wdog_en <= 1'b1;
        apb(1'b1, oscmc_pkg::TRIM_OFS, 32'hffff_fff0);
        apb(1'b0, oscmc_pkg::TRIM_OFS, 32'h0);
        chk(rd, 32'h10);
        chk({trim, cpu_hold, slow_en}, {5'h10, 1'b0, 1'b1});
        apb(1'b0, oscmc_pkg::CTRL_OFS, 32'h0);
        chk(rd, sv);
        apb(1'b1, 8'h0c, 32'hffff_ffff);
        chk(err, 1'b1);
        apb(1'b0, oscmc_pkg::CTRL_OFS, 32'h0);
        chk(rd, sv);
        apb(1'b1, oscmc_pkg::CTRL_OFS, 32'h01);
        repeat (3) @(posedge pclk);
        apb(1'b0, oscmc_pkg::CTRL_OFS, 32'h0);
        chk(rd[2], 1'b0);
        chk({slow_en, fast_en}, 2'h2);
    endtask

    task automatic t_pins();
        for (int m = 0; m < 8; m++) begin
            @(posedge pclk);
            mode <= 3'(m);
            @(negedge pclk);
            chk({b_oe, rel_a, rel_b, gain}, pins[m]);
        end
    endtask

    // Pin B rises once per k pin A rising edges
    task automatic t_divide(input logic [2:0] m, input int k);
        int b0, e0, db, de;
        rst(m, 1'b0);
        run <= 1'b1;
        wait_run(400);
        b0 = b_rises;
        e0 = edges;
        repeat (3000) @(posedge pclk);
        db = (b_rises - b0) * k;
        de = edges - e0;
        chk(db >= de - 2 * k && db <= de + 2 * k, 1'b1);
    endtask

    task automatic t_xtal();
        rst(oscmc_pkg::MODE_MEDIUM, 1'b1);
        run <= 1'b1;
        repeat (300) @(posedge pclk);
        chk(cpu_hold, 1'b1);
        put_done <= 1'b1;
        clr <= 1'b1;
        @(posedge pclk);
        clr <= 1'b0;
        n = 0;
        while (edges < 500 && n < 10000) begin
            @(posedge pclk);
            n++;
        end
        run <= 1'b0;
        repeat (500) @(posedge pclk);
        chk(cpu_hold, 1'b1);
        run <= 1'b1;
        slow <= 1'b1;
        wait_run(20000);
        chk(edges >= 1023 && edges <= 1026, 1'b1);
        chk(gain, oscmc_pkg::GAIN_MID);
        @(posedge pclk);
        wake <= 1'b1;
        clr <= 1'b1;
        @(posedge pclk);
        wake <= 1'b0;
        clr <= 1'b0;
        slow <= 1'b0;
        repeat (3) @(negedge pclk);
        chk(cpu_hold, 1'b1);
        wait_run(20000);
        chk(edges >= 1022 && edges <= 1026, 1'b1);
    endtask

    task automatic t_starts();
        rst(oscmc_pkg::MODE_DRIVEN, 1'b0);
        wait_run(50);
        chk(n >= 2 && n <= 4, 1'b1);
        rst(oscmc_pkg::MODE_INTIO, 1'b0);
        wait_run(500);
        chk(n >= 199 && n <= 205, 1'b1);
    endtask

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Whole run needs about 30k cycles; allow three times that
    initial begin
        #1_000_000;
        miscompares++;
        close_out();
    end

    initial begin
        t_regs();
        t_pins();
        t_divide(oscmc_pkg::MODE_RC, 4);
        t_divide(oscmc_pkg::MODE_INTOUT, 8);
        t_xtal();
        t_starts();
        close_out();
    end
endmodule
